// ==== include/mir_pkg.sv ====
// Package for the group seven to nine interrupt request and enable registers.
// Assumes a single 50 MHz clock domain and an AXI4-Lite register port with 32-bit data.
package mir_pkg;

	// ==========================================================
	// Register map, byte addresses on the AXI4-Lite port
	// ==========================================================
	localparam int              ADDR_W      = 8;      // Width of the register address
	localparam logic [7:0]      ADDR_GRP7   = 8'h00;  // Group seven flags and enables
	localparam logic [7:0]      ADDR_GRP8   = 8'h04;  // Group eight flags and enables
	localparam logic [7:0]      ADDR_GRP9   = 8'h08;  // Group nine flags and enables
	localparam logic [7:0]      ADDR_STATUS = 8'h0C;  // Sticky group event status, write one to clear
	localparam logic [7:0]      ADDR_MASK   = 8'h10;  // Interrupt mask, same layout as status

	// ==========================================================
	// Decoded register indices
	// ==========================================================
	localparam logic [2:0]      IDX_GRP7    = 3'h0;   // First group index
	localparam logic [2:0]      IDX_STATUS  = 3'h3;   // Status register
	localparam logic [2:0]      IDX_MASK    = 3'h4;   // Mask register
	localparam logic [2:0]      IDX_NONE    = 3'h7;   // Unmapped address

	// ==========================================================
	// Group register layout
	// ==========================================================
	localparam int              GROUPS      = 3;      // Groups seven, eight and nine
	localparam int              SRC_PER_GRP = 3;      // Sources in each group
	localparam int              FLAG_LSB    = 4;      // Flags sit in bits 6..4
	localparam int              EN_LSB      = 0;      // Enables sit in bits 2..0
	localparam logic [7:0]      IMPL_MASK   = 8'h77;  // Implemented bits of a group register
	localparam logic [7:0]      UNIMPL_MASK = 8'h88;  // Bits 7 and 3 always read zero
	localparam logic [2:0]      FIELD_RESET = 3'h0;   // Flags and enables after reset

	// ==========================================================
	// Bus answers
	// ==========================================================
	localparam logic [1:0]      RESP_OKAY   = 2'h0;   // Normal access
	localparam logic [1:0]      RESP_SLVERR = 2'h2;   // Unmapped address

endpackage : mir_pkg

// ==== hdl/mir_group_reg.sv ====
// One group register: three request flags, three enables and the combined group flag.
// Assumes source events are one-cycle pulses from logic on the same clock.
`timescale 1ns/1ps

module mir_group_reg (
	input  wire logic       clk,          // System clock
	input  wire logic       sys_rst,      // Asynchronous reset, active high
	input  wire logic [2:0] src_event,    // Source pulses: [2] bit 6, [1] bit 5, [0] bit 4
	input  wire logic       wr_en,        // Software write to this register
	input  wire logic [7:0] wr_data,      // Write data, low byte
	input  wire logic       svc_ack,      // Core services this group
	output logic      [7:0] reg_value,    // Read view of the register
	output logic            group_flag,   // Combined group request flag
	output logic            group_req,    // Flag set and enabled for some source
	output logic            new_flag      // Pulse: some flag went from zero to one
);

	// ==========================================================
	// State
	// ==========================================================
	logic [2:0] flags;          // Request flags, bits 6..4
	logic [2:0] enables;        // Enable bits, bits 2..0
	logic       comb_flag;      // Combined flag of the group
	logic [2:0] next_flags;     // Next request flags
	logic [2:0] next_enables;   // Next enables
	logic       next_comb_flag; // Next combined flag
	logic [2:0] rising;         // Flags newly set this cycle

	// Next values: a source pulse wins over a software write of zero
	always_comb begin
		next_flags     = src_event | (wr_en ? wr_data[mir_pkg::FLAG_LSB +: mir_pkg::SRC_PER_GRP] : flags); // [RULE2] [RULE3] [RULE6] [RULE8]
		next_enables   = wr_en ? wr_data[mir_pkg::EN_LSB +: mir_pkg::SRC_PER_GRP] : enables; // [RULE4] [RULE5] [RULE7] [RULE9]
		rising         = next_flags & ~flags;
		// Servicing clears only the combined flag; sources stay for software
		next_comb_flag = (|rising) | (comb_flag & ~svc_ack); // [RULE11] [RULE12]
	end

	// Register the state
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			flags     <= mir_pkg::FIELD_RESET; // [RULE10]
			enables   <= mir_pkg::FIELD_RESET; // [RULE10]
			comb_flag <= 1'b0;
			new_flag  <= 1'b0;
		end else begin
			flags     <= next_flags;
			enables   <= next_enables;
			comb_flag <= next_comb_flag;
			new_flag  <= |rising;
		end
	end

	// Unimplemented bits 7 and 3 read zero and drop writes
	assign reg_value  = {1'b0, flags, 1'b0, enables}; // [RULE1]
	assign group_flag = comb_flag;
	assign group_req  = |(flags & enables);

endmodule : mir_group_reg

// ==== hdl/mir_top.sv ====
// Request and enable registers of interrupt groups seven to nine behind an AXI4-Lite slave.
// Assumes source pulses and service acknowledges come from logic on the same 50 MHz clock.
//
// Summary of operation
// RULE1 - Bits seven and three read zero, ignore writes
// RULE2 - Group seven bit six: comparator one flag
// RULE3 - Group seven bits five, four: timer five flags
// RULE4 - Group seven bits two, one: enables
// RULE5 - Group seven bit zero: timer five P enable
// RULE6 - Group eight bits six to four: flags
// RULE7 - Group eight bits two to zero: enables
// RULE8 - Group nine bits six to four: flags
// RULE9 - Group nine bits two to zero: enables
// RULE10 - All flags and enables clear at reset
// RULE11 - Combined flag sets on source, clears on service
// RULE12 - Service leaves source flags for software
`timescale 1ns/1ps

module mir_top (
	input  wire logic        clk,            // System clock, 50 MHz
	input  wire logic        sys_rst,        // Asynchronous reset, active high
	input  wire logic [7:0]  s_axi_awaddr,   // Write address
	input  wire logic        s_axi_awvalid,  // Write address valid
	output logic             s_axi_awready,  // Write address ready
	input  wire logic [31:0] s_axi_wdata,    // Write data
	input  wire logic [3:0]  s_axi_wstrb,    // Write byte strobes
	input  wire logic        s_axi_wvalid,   // Write data valid
	output logic             s_axi_wready,   // Write data ready
	output logic [1:0]       s_axi_bresp,    // Write response
	output logic             s_axi_bvalid,   // Write response valid
	input  wire logic        s_axi_bready,   // Write response ready
	input  wire logic [7:0]  s_axi_araddr,   // Read address
	input  wire logic        s_axi_arvalid,  // Read address valid
	output logic             s_axi_arready,  // Read address ready
	output logic [31:0]      s_axi_rdata,    // Read data
	output logic [1:0]       s_axi_rresp,    // Read response
	output logic             s_axi_rvalid,   // Read data valid
	input  wire logic        s_axi_rready,   // Read data ready
	input  wire logic [8:0]  src_event,      // Source pulses, three per group
	input  wire logic [2:0]  svc_ack,        // Service pulse per group
	output logic [2:0]       group_flag,     // Combined group flags
	output logic [2:0]       group_req,      // Enabled pending request per group
	output logic             irq             // Level interrupt
);

	// ==========================================================
	// Address decode shared by the write and read paths
	// ==========================================================
	function automatic logic [2:0] mir_decode(input logic [7:0] addr);
		case (addr)
			mir_pkg::ADDR_GRP7:   mir_decode = mir_pkg::IDX_GRP7;
			mir_pkg::ADDR_GRP8:   mir_decode = 3'h1;
			mir_pkg::ADDR_GRP9:   mir_decode = 3'h2;
			mir_pkg::ADDR_STATUS: mir_decode = mir_pkg::IDX_STATUS;
			mir_pkg::ADDR_MASK:   mir_decode = mir_pkg::IDX_MASK;
			default:              mir_decode = mir_pkg::IDX_NONE;
		endcase
	endfunction : mir_decode

	// ==========================================================
	// Write channel
	// ==========================================================
	logic        aw_held;        // Address taken, waiting for data
	logic        w_held;         // Data taken, waiting for address
	logic [7:0]  aw_addr_q;      // Held write address
	logic [31:0] w_data_q;       // Held write data
	logic [3:0]  w_strb_q;       // Held strobes
	logic        next_aw_held;   // Next address held
	logic        next_w_held;    // Next data held
	logic [7:0]  next_aw_addr_q; // Next held address
	logic [31:0] next_w_data_q;  // Next held data
	logic [3:0]  next_w_strb_q;  // Next held strobes
	logic        next_bvalid;    // Next response valid
	logic [1:0]  next_bresp;     // Next response code
	logic        aw_take;        // Address handshake
	logic        w_take;         // Data handshake
	logic        do_write;       // Both halves present this cycle
	logic [7:0]  wr_addr;        // Effective write address
	logic [31:0] wr_data;        // Effective write data
	logic        wr_lane0;       // Low byte lane written
	logic [2:0]  wr_idx;         // Decoded write target

	// Ready while the half is not held and no response is pending
	assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
	assign aw_take       = s_axi_awvalid & s_axi_awready;
	assign w_take        = s_axi_wvalid & s_axi_wready;
	assign do_write      = (aw_held | aw_take) & (w_held | w_take);
	assign wr_addr       = aw_held ? aw_addr_q : s_axi_awaddr;
	assign wr_data       = w_held ? w_data_q : s_axi_wdata;
	assign wr_lane0      = w_held ? w_strb_q[0] : s_axi_wstrb[0];
	assign wr_idx        = mir_decode(wr_addr);

	// Next write channel state: halves taken in either order, answer after both
	always_comb begin
		next_aw_held   = aw_held;
		next_w_held    = w_held;
		next_aw_addr_q = aw_addr_q;
		next_w_data_q  = w_data_q;
		next_w_strb_q  = w_strb_q;
		next_bvalid    = s_axi_bvalid & ~s_axi_bready;
		next_bresp     = s_axi_bresp;
		if (do_write) begin
			// Write performed now; response in the next cycle
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = (wr_idx == mir_pkg::IDX_NONE) ? mir_pkg::RESP_SLVERR : mir_pkg::RESP_OKAY;
		end else begin
			// Keep whichever half arrived first
			if (aw_take) begin
				next_aw_held   = 1'b1;
				next_aw_addr_q = s_axi_awaddr;
			end
			if (w_take) begin
				next_w_held   = 1'b1;
				next_w_data_q = s_axi_wdata;
				next_w_strb_q = s_axi_wstrb;
			end
		end
	end

	// Register the write channel
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr_q    <= 8'h00;
			w_data_q     <= 32'h00000000;
			w_strb_q     <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= mir_pkg::RESP_OKAY;
		end else begin
			aw_held      <= next_aw_held;
			w_held       <= next_w_held;
			aw_addr_q    <= next_aw_addr_q;
			w_data_q     <= next_w_data_q;
			w_strb_q     <= next_w_strb_q;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp  <= next_bresp;
		end
	end

	// ==========================================================
	// Group registers
	// ==========================================================
	logic [7:0] grp_value [mir_pkg::GROUPS]; // Read view per group
	logic [2:0] new_flag;                    // Flag-set pulse per group

	for (genvar g = 0; g < mir_pkg::GROUPS; g++) begin : g_grp
		mir_group_reg u_grp (
			.clk        (clk),
			.sys_rst    (sys_rst),
			.src_event  (src_event[g*mir_pkg::SRC_PER_GRP +: mir_pkg::SRC_PER_GRP]),
			.wr_en      (do_write & wr_lane0 & (wr_idx == 3'(g))),
			.wr_data    (wr_data[7:0]),
			.svc_ack    (svc_ack[g]),
			.reg_value  (grp_value[g]),
			.group_flag (group_flag[g]),
			.group_req  (group_req[g]),
			.new_flag   (new_flag[g])
		);
	end

	// ==========================================================
	// Status and mask
	// ==========================================================
	logic [2:0] status;      // Sticky group events
	logic [2:0] mask;        // Interrupt mask
	logic [2:0] next_status; // Next status
	logic [2:0] next_mask;   // Next mask
	logic [2:0] clr_bits;    // Write-one-to-clear pattern

	// A new event in the clearing cycle keeps its bit set
	always_comb begin
		clr_bits    = (do_write & wr_lane0 & (wr_idx == mir_pkg::IDX_STATUS)) ? wr_data[2:0] : 3'h0;
		next_status = new_flag | (status & ~clr_bits);
		next_mask   = (do_write & wr_lane0 & (wr_idx == mir_pkg::IDX_MASK)) ? wr_data[2:0] : mask;
	end

	// Register status and mask
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			status <= 3'h0;
			mask   <= 3'h0;
		end else begin
			status <= next_status;
			mask   <= next_mask;
		end
	end

	assign irq = |(status & mask);

	// ==========================================================
	// Read channel
	// ==========================================================
	logic [31:0] next_rdata;  // Next read data
	logic [1:0]  next_rresp;  // Next read response
	logic        next_rvalid; // Next read valid
	logic [2:0]  rd_idx;      // Decoded read target

	assign s_axi_arready = ~s_axi_rvalid;
	assign rd_idx        = mir_decode(s_axi_araddr);

	// Capture the addressed register in the address handshake cycle; data is valid in the next cycle
	always_comb begin
		next_rdata  = s_axi_rdata;
		next_rresp  = s_axi_rresp;
		next_rvalid = s_axi_rvalid & ~s_axi_rready;
		if (s_axi_arvalid & s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp  = mir_pkg::RESP_OKAY;
			case (rd_idx)
				3'h0, 3'h1, 3'h2:    next_rdata = {24'h000000, grp_value[rd_idx[1:0]]}; // [RULE1]
				mir_pkg::IDX_STATUS: next_rdata = {29'h00000000, status};
				mir_pkg::IDX_MASK:   next_rdata = {29'h00000000, mask};
				default: begin
					next_rdata = 32'h00000000;
					next_rresp = mir_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	// Register the read channel
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= mir_pkg::RESP_OKAY;
			s_axi_rvalid <= 1'b0;
		end else begin
			s_axi_rdata  <= next_rdata;
			s_axi_rresp  <= next_rresp;
			s_axi_rvalid <= next_rvalid;
		end
	end

	// ==========================================================
	// Assertions
	// ==========================================================
	default clocking mir_cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	logic [7:0] g7; // Group seven view
	logic [7:0] g8; // Group eight view
	logic [7:0] g9; // Group nine view
	assign g7 = grp_value[0];
	assign g8 = grp_value[1];
	assign g9 = grp_value[2];

	unimpl_zero_a: assert property (((g7 | g8 | g9) & mir_pkg::UNIMPL_MASK) == 8'h00) // [RULE1]
		else $error("Unimplemented group bit reads one");
	cmp1_flag_a: assert property (src_event[2] |=> g7[6]) // [RULE2]
		else $error("Comparator one flag not set by its source");
	t5_flags_a: assert property (src_event[1:0] != 2'h0 |=> (g7[5:4] & $past(src_event[1:0])) == $past(src_event[1:0])) // [RULE3]
		else $error("Timer five flag not set by its source");
	g7_enable_a: assert property (do_write && wr_lane0 && wr_idx == 3'h0 |=> g7[2:0] == $past(wr_data[2:0])) // [RULE4] [RULE5]
		else $error("Group seven enables do not follow the write");
	g8_flags_a: assert property (src_event[5:3] != 3'h0 |=> (g8[6:4] & $past(src_event[5:3])) == $past(src_event[5:3])) // [RULE6]
		else $error("Group eight flag not set by its source");
	g8_enable_a: assert property (do_write && wr_lane0 && wr_idx == 3'h1 |=> g8[2:0] == $past(wr_data[2:0])) // [RULE7]
		else $error("Group eight enables do not follow the write");
	g9_flags_a: assert property (src_event[8:6] != 3'h0 |=> (g9[6:4] & $past(src_event[8:6])) == $past(src_event[8:6])) // [RULE8]
		else $error("Group nine flag not set by its source");
	g9_enable_a: assert property (do_write && wr_lane0 && wr_idx == 3'h2 |=> g9[2:0] == $past(wr_data[2:0])) // [RULE9]
		else $error("Group nine enables do not follow the write");
	reset_clear_a: assert property (@(posedge clk) disable iff (1'b0)
		sys_rst |-> ((g7 | g8 | g9) == 8'h00) && group_flag == 3'h0) // [RULE10]
		else $error("Group registers not clear during reset");
	comb_set_a: assert property (src_event[2:0] != 3'h0 && g7[6:4] == 3'h0 |=> group_flag[0] ##1 status[0]) // [RULE11]
		else $error("Combined flag or status not set after a source event");
	comb_clear_a: assert property (svc_ack[1] && src_event[5:3] == 3'h0 && !(do_write && wr_idx == 3'h1)
		|=> !group_flag[1] && g8[6:4] == $past(g8[6:4])) // [RULE11] [RULE12]
		else $error("Service did not clear only the combined flag");

	write_seen_c: cover property (do_write && wr_idx == 3'h0 ##1 s_axi_bvalid);
	irq_seen_c:   cover property (src_event[3] ##[1:40] irq);
	svc_seen_c:   cover property (group_flag[2] ##1 svc_ack[2] ##1 !group_flag[2]);

endmodule : mir_top

// ==== bench/mir_src_model.sv ====
// Model of the far side: interrupt sources and the core's service sequencer.
// Assumes the bench raises fire and svc for one cycle; pulses leave here one cycle later.
`timescale 1ns/1ps

module mir_src_model (
	input  wire logic       clk,        // System clock
	input  wire logic       sys_rst,    // Asynchronous reset, active high
	input  wire logic [8:0] fire,       // Bench order: raise these source events
	input  wire logic [2:0] svc,        // Bench order: service these groups
	output logic      [8:0] src_event,  // One-cycle source pulses
	output logic      [2:0] svc_ack     // One-cycle service pulses
);
	// ==========================================================
	// Pulse generation
	// ==========================================================
	// Registered so each event is exactly one cycle on the design clock
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			src_event <= 9'h000;
			svc_ack   <= 3'h0;
		end else begin
			src_event <= fire;
			// Service only acknowledges the group; source flags stay for software
			svc_ack   <= svc;
		end
	end
endmodule : mir_src_model

// ==== bench/tb_multifunction_irq_regs_7_to_9.sv ====
// Self-checking bench for the group seven to nine request and enable registers.
// Assumes the package and the source model are compiled first; one 50 MHz clock.
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

module tb_multifunction_irq_regs_7_to_9;
	// ==========================================================
	// Signals
	// ==========================================================
	logic        clk;            // System clock
	logic        sys_rst;        // Reset, active high
	logic [7:0]  s_axi_awaddr;   // Write channel
	logic        s_axi_awvalid;
	logic        s_axi_awready;
	logic [31:0] s_axi_wdata;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_wvalid;
	logic        s_axi_wready;
	logic [1:0]  s_axi_bresp;
	logic        s_axi_bvalid;
	logic        s_axi_bready;
	logic [7:0]  s_axi_araddr;   // Read channel
	logic        s_axi_arvalid;
	logic        s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_rresp;
	logic        s_axi_rvalid;
	logic        s_axi_rready;
	logic [8:0]  fire;           // Orders to the source model
	logic [2:0]  svc;
	logic [8:0]  src_event;
	logic [2:0]  svc_ack;
	logic [2:0]  group_flag;
	logic [2:0]  group_req;
	logic        irq;
	int          num_errors;     // Mismatches seen
	int          checks;         // Comparisons made
	int          cycles;         // Timeout counter
	int          seed;           // Random seed

	mir_top u_dut (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.src_event(src_event), .svc_ack(svc_ack), .group_flag(group_flag), .group_req(group_req), .irq(irq));

	mir_src_model u_src (.clk(clk), .sys_rst(sys_rst), .fire(fire), .svc(svc), .src_event(src_event),
		.svc_ack(svc_ack));

	// ==========================================================
	// Clock, timeout and verdict
	// ==========================================================
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Cuts a hang short; the full run needs well under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			test_done();
		end
	end

	task automatic test_done();
		if (num_errors == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done

	// ==========================================================
	// Bus tasks: request after an edge, hold until taken
	// ==========================================================
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd

	// Expected flag and enable bit of a source
	function automatic logic [31:0] flag_bit(input int k);
		return 32'h1 << (mir_pkg::FLAG_LSB + k % 3);
	endfunction : flag_bit

	function automatic logic [31:0] en_bit(input int k);
		return 32'h1 << (mir_pkg::EN_LSB + k % 3);
	endfunction : en_bit

	// ==========================================================
	// Main sequence
	// ==========================================================
	initial begin
		logic [31:0] d;
		logic [31:0] q;
		logic [1:0]  r;
		logic [7:0]  a;
		int          g;
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready, fire, svc} = '0;
		s_axi_wstrb = 4'hF;
		num_errors = 0;
		checks = 0;
		cycles = 0;
		seed = 32'h0c1e;
		// Raise reset after time zero so every flop sees a clean rising edge of it
		sys_rst = 1'b0;
		#1;
		sys_rst = 1'b1;
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		// Every register clears at reset, unmapped address refused
		for (int i = 0; i < 5; i++) begin
			rd(8'(i * 4), d, r);
			`CHK(d, 32'h0)
		end
		rd(8'h14, d, r);
		`CHK(r, mir_pkg::RESP_SLVERR)
		wr(8'h14, 32'hFF, r);
		`CHK(r, mir_pkg::RESP_SLVERR)
		// All ones first, then random data, back to back on all groups
		for (int k = 0; k < 12; k++) begin
			a = mir_pkg::ADDR_GRP7 + 8'((k % 3) * 4);
			d = (k < 3) ? 32'hFFFF_FFFF : $random(seed);
			wr(a, d, r);
			`CHK(r, mir_pkg::RESP_OKAY)
			rd(a, q, r);
			`CHK(r, mir_pkg::RESP_OKAY)
			`CHK(q, {24'h0, d[7:0] & mir_pkg::IMPL_MASK})
		end
		// Low byte lane off: the write is answered but leaves the register alone
		d = q;
		s_axi_wstrb <= 4'hE;
		wr(a, ~d, r);
		s_axi_wstrb <= 4'hF;
		`CHK(r, mir_pkg::RESP_OKAY)
		rd(a, q, r);
		`CHK(q, d)
		for (int k = 0; k < 3; k++) wr(mir_pkg::ADDR_GRP7 + 8'(k * 4), 32'h0, r);
		wr(mir_pkg::ADDR_STATUS, 32'h7, r);
		svc <= 3'h7;
		@(posedge clk);
		svc <= 3'h0;
		// Each source in turn: flag, combined flag, enable, interrupt, service, clear
		for (int k = 0; k < 9; k++) begin
			g = k / 3;
			a = mir_pkg::ADDR_GRP7 + 8'(g * 4);
			@(posedge clk);
			fire <= 9'h1 << k;
			@(posedge clk);
			fire <= 9'h0;
			repeat (3) @(posedge clk);
			`CHK(group_flag[g], 1'b1)
			`CHK(group_req[g], 1'b0)
			`CHK(irq, 1'b0)
			rd(a, q, r);
			`CHK(q, flag_bit(k))
			wr(a, flag_bit(k) | en_bit(k), r);
			`CHK(group_req[g], 1'b1)
			wr(mir_pkg::ADDR_MASK, 32'h1 << g, r);
			`CHK(irq, 1'b1)
			svc <= 3'h1 << g;
			@(posedge clk);
			svc <= 3'h0;
			repeat (3) @(posedge clk);
			`CHK(group_flag[g], 1'b0)
			rd(a, q, r);
			`CHK(q, flag_bit(k) | en_bit(k))
			wr(mir_pkg::ADDR_STATUS, 32'h1 << g, r);
			`CHK(irq, 1'b0)
			// Software clears the source flag itself
			wr(a, 32'h0, r);
			`CHK(group_req[g], 1'b0)
			wr(mir_pkg::ADDR_MASK, 32'h0, r);
		end
		test_done();
	end
endmodule : tb_multifunction_irq_regs_7_to_9
